// ===== design/sensor_readout_pkg.sv
// Package with frame geometry, sync patterns and sequencer states of the sensor readout
package sensor_readout_pkg;

	// Frame geometry
	localparam int IMAGE_COLUMNS = 280;
	localparam int DUMMY_COLUMNS = 1;
	localparam int PIXELS_PER_COLUMN = 8;
	localparam int PIXELS_PER_BYTE = 2;
	localparam int BYTES_PER_COLUMN = PIXELS_PER_COLUMN / PIXELS_PER_BYTE;
	localparam int FRAME_BYTES = (IMAGE_COLUMNS + DUMMY_COLUMNS) * BYTES_PER_COLUMN;
	localparam int IMAGE_BYTES = IMAGE_COLUMNS * BYTES_PER_COLUMN;

	// Widths
	localparam int NIBBLE_W = 4;
	localparam int POS_W = 11;
	localparam int COL_W = 9;
	localparam int ROW_W = 2;
	localparam int TEMP_W = 16;

	// Start sequence pipeline fill
	localparam int FILL_PULSES = 4;
	localparam int FILL_W = 3;

	// Dummy column byte positions within the frame
	localparam logic [POS_W-1:0] POS_SYNC_FIRST = 11'(IMAGE_BYTES);
	localparam logic [POS_W-1:0] POS_SYNC_SECOND = 11'(IMAGE_BYTES + 1);
	localparam logic [POS_W-1:0] POS_TEMP_FIRST = 11'(IMAGE_BYTES + 2);
	localparam logic [POS_W-1:0] POS_TEMP_SECOND = 11'(IMAGE_BYTES + 3);
	localparam logic [POS_W-1:0] POS_LAST = 11'(FRAME_BYTES - 1);

	// Fixed sync pattern of the dummy column
	localparam logic [NIBBLE_W-1:0] SYNC_EVEN = 4'h0;
	localparam logic [NIBBLE_W-1:0] SYNC_ODD = 4'hf;

	// Reset values
	localparam logic [NIBBLE_W-1:0] NIBBLE_RESET = 4'h0;

	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_HOLD,
		SEQ_FILL,
		SEQ_RUN
	} seq_state_type;

endpackage : sensor_readout_pkg

// ===== design/pixel_pair_buffer.sv
// Two-entry buffer for pixel pairs between the converter and the readout sequencer
`timescale 1ns/1ps

module pixel_pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Filling side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Draining side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);

	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
	logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
	logic [CNT_W-1:0] count_q, count_d;
	logic full_q, full_d;
	logic empty_q, empty_d;
	logic push;
	logic pop;

	// Pointer, count and flag update; flags are registered so ready and valid come from flops
	always_comb begin
		push = in_valid_i && !full_q;
		pop = out_ready_i && !empty_q;
		mem_d = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push) begin
			mem_d[wr_ptr_q] = in_data_i;
			wr_ptr_d = (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
		end
		if (pop) begin
			rd_ptr_d = (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
		end
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
		full_d = (count_d == CNT_W'(DEPTH));
		empty_d = (count_d == '0);
	end

	// State registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
			full_q <= full_d;
			empty_q <= empty_d;
		end
	end

	// Storage needs no reset
	always_ff @(posedge mclk_i) begin
		mem_q <= mem_d;
	end

	assign in_ready_o = !full_q;
	assign out_valid_o = !empty_q;
	assign out_data_o = mem_q[rd_ptr_q];

endmodule : pixel_pair_buffer

// ===== design/swept_sensor_frame_readout.sv
// Digital frame readout of a swept linear pixel-array sensor
//
// Contract
// - First frame after start carries no valid image; host discards it.
// - Frame is 280 image columns plus one dummy column, 1124 clocks.
// - Device acts on pixel clock falling edge, updates data on rising edge.
// - Each pulse after start presents a new odd and even nibble byte.
// - Data outputs driven only while output enable low, else released.
// - No transaction mode; sequencing runs regardless of output enable.
// - Pixels 1-3-5-7 go on odd nibble, 2-4-6-8 on even nibble.
// - Nibble bit three is the most significant, bit zero the least.
// - After reset, readout starts with pixel number one.
// - First two dummy bytes carry even 0000 and odd 1111.
// - Third and fourth dummy bytes carry raw temperature nibbles.
// - Sync byte pair recurs every 1124 pixel clocks.
`timescale 1ns/1ps

module swept_sensor_frame_readout (
	// System clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Host pins
	input wire logic pclk_i,
	input wire logic rst_i,
	input wire logic oe_n_i,
	output logic [sensor_readout_pkg::NIBBLE_W-1:0] odd_pixel_nibble_o,
	output logic [sensor_readout_pkg::NIBBLE_W-1:0] even_pixel_nibble_o,
	output logic data_oe_o,
	// Converter side pixel pairs
	input wire logic pixel_valid_i,
	input wire logic [sensor_readout_pkg::NIBBLE_W-1:0] odd_pixel_i,
	input wire logic [sensor_readout_pkg::NIBBLE_W-1:0] even_pixel_i,
	output logic pixel_ready_o,
	input wire logic [sensor_readout_pkg::TEMP_W-1:0] temp_word_i,
	// Readout position and status
	output logic [sensor_readout_pkg::COL_W-1:0] column_o,
	output logic [sensor_readout_pkg::ROW_W-1:0] row_pair_o,
	output logic first_frame_o,
	output logic underrun_o
);

	import sensor_readout_pkg::*;

	localparam int BYTE_W = 2 * NIBBLE_W;

	// Pin synchronisers: stage 1 read only by stage 2
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic pclk_s3_q;
	logic pclk_fall;
	logic pclk_rise;
	logic rst_sync;
	logic oe_n_sync;

	// Sequencer state
	seq_state_type state_q, state_d;
	logic [FILL_W-1:0] fill_q, fill_d;
	logic [POS_W-1:0] pos_q, pos_d;
	logic [BYTE_W-1:0] staged_q, staged_d;
	logic first_frame_q, first_frame_d;
	logic underrun_q, underrun_d;
	logic pop;
	logic stage_img;
	logic frame_wrap;
	// Temperature word held across the dummy column
	logic [TEMP_W-1:0] temp_snap_q, temp_snap_d;

	// Pin side registers
	logic [NIBBLE_W-1:0] odd_q, odd_d;
	logic [NIBBLE_W-1:0] even_q, even_d;
	logic data_oe_q, data_oe_d;
	logic [COL_W-1:0] column_q, column_d;
	logic [ROW_W-1:0] row_q, row_d;

	// Buffer wiring
	logic buf_valid;
	logic [BYTE_W-1:0] buf_data;
	logic buf_in_ready;

	// Two-flop synchronisers plus one extra stage on the pixel clock for edges
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			// Idle pin levels: output enable high, reset high, clock low
			pin_s1_q <= 3'h6;
			pin_s2_q <= 3'h6;
			pclk_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= {oe_n_i, rst_i, pclk_i};
			pin_s2_q <= pin_s1_q;
			pclk_s3_q <= pin_s2_q[0];
		end
	end

	// Edge and level decode of the synchronised pins
	assign pclk_fall = pclk_s3_q && !pin_s2_q[0];
	assign pclk_rise = !pclk_s3_q && pin_s2_q[0];
	assign rst_sync = pin_s2_q[1];
	assign oe_n_sync = pin_s2_q[2];

	// Pixel pair buffer between converter and sequencer
	pixel_pair_buffer #(
		.WIDTH(BYTE_W),
		.DEPTH(2)
	) u_pair_buffer (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.in_valid_i(pixel_valid_i),
		.in_data_i({odd_pixel_i, even_pixel_i}),
		.in_ready_o(buf_in_ready),
		.out_valid_o(buf_valid),
		.out_data_o(buf_data),
		.out_ready_i(pop)
	);

	// Sequencer: start sequence, frame position and byte staging on falling edges
	always_comb begin
		state_d = state_q;
		fill_d = fill_q;
		pos_d = pos_q;
		staged_d = staged_q;
		stage_img = 1'b0;
		frame_wrap = 1'b0;
		pop = 1'b0;
		if (rst_sync) begin
			// Hold at frame start while reset is high
			state_d = SEQ_HOLD;
			fill_d = '0;
			pos_d = '0;
			staged_d = '0;
		end else begin
			unique case (state_q)
				SEQ_HOLD: begin
					state_d = SEQ_FILL;
				end
				SEQ_FILL: begin
					if (pclk_fall) begin
						fill_d = fill_q + 1'b1;
						if (fill_q == FILL_W'(FILL_PULSES - 1)) begin
							// Fourth pulse stages byte 0, so the next fall stages byte 1
							state_d = SEQ_RUN;
							pos_d = pos_q + 1'b1;
						end
					end
				end
				SEQ_RUN: begin
					// Advances on every clock, output enable plays no part
					if (pclk_fall) begin
						pos_d = (pos_q == POS_LAST) ? '0 : pos_q + 1'b1;
						frame_wrap = (pos_q == '0);
					end
				end
			endcase
			// Stage the byte for the current frame position
			if (pclk_fall && (state_d == SEQ_RUN)) begin
				if (pos_q < POS_SYNC_FIRST) begin
					// Buffer holds odd pixel 2b+1 and even pixel 2b+2
					stage_img = 1'b1;
					pop = buf_valid;
					staged_d = buf_valid ? buf_data : '0;
				end else if (pos_q == POS_SYNC_FIRST || pos_q == POS_SYNC_SECOND) begin
					staged_d = {SYNC_ODD, SYNC_EVEN};
				end else if (pos_q == POS_TEMP_FIRST) begin
					staged_d = {temp_snap_q[11:8], temp_snap_q[15:12]};
				end else begin
					staged_d = {temp_snap_q[3:0], temp_snap_q[7:4]};
				end
			end
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			state_q <= SEQ_HOLD;
			fill_q <= '0;
			pos_q <= '0;
			staged_q <= '0;
		end else begin
			state_q <= state_d;
			fill_q <= fill_d;
			pos_q <= pos_d;
			staged_q <= staged_d;
		end
	end

	// Temperature word captured once per dummy column so both bytes come from one sample
	always_comb begin
		temp_snap_d = temp_snap_q;
		if (pclk_fall && !rst_sync && state_q == SEQ_RUN && pos_q == POS_SYNC_FIRST) begin
			temp_snap_d = temp_word_i;
		end
	end

	// Temperature snapshot register
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			temp_snap_q <= '0;
		end else begin
			temp_snap_q <= temp_snap_d;
		end
	end

	// Status flags: first frame after start and sticky starvation of the image path
	always_comb begin
		first_frame_d = first_frame_q;
		underrun_d = underrun_q;
		// First frame after a start sequence stays flagged until the frame wraps
		if (rst_sync) begin
			first_frame_d = 1'b1;
		end else if (frame_wrap) begin
			first_frame_d = 1'b0;
		end
		// Starved image byte goes out as zeros; only the system reset clears the flag
		if (stage_img && !buf_valid) begin
			underrun_d = 1'b1;
		end
	end

	// Status flag registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			first_frame_q <= 1'b1;
			underrun_q <= 1'b0;
		end else begin
			first_frame_q <= first_frame_d;
			underrun_q <= underrun_d;
		end
	end

	// Pin side: data update on rising edges, enable follows the output enable pin
	always_comb begin
		odd_d = odd_q;
		even_d = even_q;
		// Bus drive follows the pin on every clock, independent of sequencing
		data_oe_d = !oe_n_sync;
		if (rst_sync) begin
			odd_d = NIBBLE_RESET;
			even_d = NIBBLE_RESET;
		end else if (pclk_rise && state_q == SEQ_RUN) begin
			// Bit 3 of each nibble is its most significant bit
			odd_d = staged_q[BYTE_W-1:NIBBLE_W];
			even_d = staged_q[NIBBLE_W-1:0];
		end
	end

	// Pin side registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			odd_q <= NIBBLE_RESET;
			even_q <= NIBBLE_RESET;
			data_oe_q <= 1'b0;
		end else begin
			odd_q <= odd_d;
			even_q <= even_d;
			data_oe_q <= data_oe_d;
		end
	end

	// Position of the byte the converter should deliver next
	always_comb begin
		column_d = COL_W'(pos_q / POS_W'(BYTES_PER_COLUMN));
		row_d = pos_q[ROW_W-1:0];
		if (rst_sync) begin
			column_d = '0;
			row_d = '0;
		end
	end

	// Position report registers
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			column_q <= '0;
			row_q <= '0;
		end else begin
			column_q <= column_d;
			row_q <= row_d;
		end
	end

	// Ready toward the converter registered so the output comes from a flop
	logic pixel_ready_q;
	always_ff @(posedge mclk_i) begin
		if (!resetn_i) begin
			pixel_ready_q <= 1'b0;
		end else begin
			pixel_ready_q <= buf_in_ready;
		end
	end

	// Outputs
	assign odd_pixel_nibble_o = odd_q;
	assign even_pixel_nibble_o = even_q;
	assign data_oe_o = data_oe_q;
	assign pixel_ready_o = pixel_ready_q;
	assign column_o = column_q;
	assign row_pair_o = row_q;
	assign first_frame_o = first_frame_q;
	assign underrun_o = underrun_q;

endmodule : swept_sensor_frame_readout

// ===== testbench/host_pin_model.sv
// Host model driving the pixel clock, reset and output enable pins
`timescale 1ns/1ps
module host_pin_model (
	// Clock
	input wire logic mclk_i,
	// Host pins
	output logic pclk_o,
	output logic rst_o,
	output logic oe_n_o
);
	// Pins idle: clock still low, reset high, outputs released
	initial begin
		pclk_o = 1'b0;
		rst_o = 1'b1;
		oe_n_o = 1'b1;
	end
	// Set reset and output enable, then let the synchronisers settle
	task automatic set_pins(input logic r, input logic oe_n);
		rst_o = r;
		oe_n_o = oe_n;
		repeat (6) @(negedge mclk_i);
	endtask : set_pins
	// One pixel clock pulse of fixed length keeps the frame period regular
	task automatic pulse();
		pclk_o = 1'b1;
		repeat (6) @(negedge mclk_i);
		pclk_o = 1'b0;
		repeat (5) @(negedge mclk_i);
	endtask : pulse
endmodule : host_pin_model

// ===== testbench/frame_readout_checker.sv
// Port assertions for the frame readout
`timescale 1ns/1ps
module frame_readout_checker (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Host pins and data
	input wire logic pclk_i,
	input wire logic rst_i,
	input wire logic oe_n_i,
	input wire logic [sensor_readout_pkg::NIBBLE_W-1:0] odd_pixel_nibble_o,
	input wire logic [sensor_readout_pkg::NIBBLE_W-1:0] even_pixel_nibble_o,
	input wire logic data_oe_o,
	// Position and status
	input wire logic [sensor_readout_pkg::COL_W-1:0] column_o,
	input wire logic [sensor_readout_pkg::ROW_W-1:0] row_pair_o,
	input wire logic first_frame_o,
	input wire logic underrun_o
);
	import sensor_readout_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// Host reset held past the synchroniser
	sequence s_rst_held;
		rst_i [*5];
	endsequence
	// Pixel clock quiet low out of host reset
	sequence s_pclk_quiet;
		(!pclk_i && !rst_i) [*5];
	endsequence
	// Sequencing, flags and pins
	a_hold_position: assert property (s_rst_held |-> column_o == 9'h0 && row_pair_o == 2'h0)
		else $error("hold position");
	a_first_flag: assert property (s_rst_held |-> first_frame_o)
		else $error("first flag");
	a_data_quiet: assert property (s_pclk_quiet |->
		$stable(odd_pixel_nibble_o) && $stable(even_pixel_nibble_o)) else $error("data moved");
	a_oe_drive: assert property (!oe_n_i [*5] |-> data_oe_o)
		else $error("oe drive");
	a_oe_release: assert property (oe_n_i [*5] |-> !data_oe_o)
		else $error("oe release");
	a_column_range: assert property (column_o <= 9'(IMAGE_COLUMNS))
		else $error("column range");
	a_column_step: assert property ($changed(column_o) |-> row_pair_o == 2'h0 &&
		(column_o == 9'h0 || column_o == $past(column_o) + 9'h1)) else $error("column step");
	a_row_step: assert property ($changed(row_pair_o) |->
		row_pair_o == 2'h0 || row_pair_o == $past(row_pair_o) + 2'h1) else $error("row step");
	a_underrun_sticky: assert property (underrun_o |=> underrun_o)
		else $error("underrun dropped");
endmodule : frame_readout_checker
bind swept_sensor_frame_readout frame_readout_checker i_frame_readout_checker (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .pclk_i(pclk_i), .rst_i(rst_i), .oe_n_i(oe_n_i),
	.odd_pixel_nibble_o(odd_pixel_nibble_o), .even_pixel_nibble_o(even_pixel_nibble_o),
	.data_oe_o(data_oe_o), .column_o(column_o), .row_pair_o(row_pair_o),
	.first_frame_o(first_frame_o), .underrun_o(underrun_o));

// ===== testbench/testbench.sv
// Self-checking bench for the frame readout
`timescale 1ns/1ps
module testbench;
	import sensor_readout_pkg::*;
	// Clock, pins and observed outputs
	logic mclk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic feed_on = 1'b0;
	logic [3:0] src_q = 4'h0;
	logic [15:0] temp_word = 16'ha5c3;
	logic pclk, rst, oe_n, data_oe, ready, first_frame, underrun;
	logic [3:0] odd_nib, even_nib, last;
	logic [8:0] column;
	logic [1:0] row_pair;
	logic [7:0] data_bus;
	int bad_count = 0;
	int tests_run = 0;
	host_pin_model i_host_pin_model (.mclk_i(mclk_i), .pclk_o(pclk), .rst_o(rst), .oe_n_o(oe_n));
	swept_sensor_frame_readout i_swept_sensor_frame_readout (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .pclk_i(pclk), .rst_i(rst), .oe_n_i(oe_n),
		.odd_pixel_nibble_o(odd_nib), .even_pixel_nibble_o(even_nib), .data_oe_o(data_oe),
		.pixel_valid_i(feed_on), .odd_pixel_i(src_q), .even_pixel_i(src_q + 4'h1),
		.pixel_ready_o(ready), .temp_word_i(temp_word), .column_o(column),
		.row_pair_o(row_pair), .first_frame_o(first_frame), .underrun_o(underrun));
	// Pin level seen by the host
	assign data_bus = data_oe ? {odd_nib, even_nib} : 8'hzz;
	always #10 mclk_i = ~mclk_i;
	// Counting pixel source, one step per accepted word
	always @(negedge mclk_i) begin
		if (feed_on && ready === 1'b1) src_q <= src_q + 4'h1;
	end
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// Pulses under host reset are ignored
	task automatic t_hold();
		i_host_pin_model.set_pins(1'b1, 1'b0);
		repeat (3) i_host_pin_model.pulse();
		check({column, row_pair, odd_nib, even_nib}, 12'h0);
		check(first_frame, 1'b1);
		i_host_pin_model.set_pins(1'b0, 1'b0);
		repeat (4) i_host_pin_model.pulse();
	endtask : t_hold
	// Frame readout with dummy column, pixel order and output enable
	task automatic t_frames(input int frames, input bit img);
		int idx;
		for (int p = 0; p < frames * FRAME_BYTES; p++) begin
			idx = p % FRAME_BYTES;
			i_host_pin_model.pulse();
			if (idx == 5) check(ready, 1'b0);
			if (img && p == 0) check({odd_nib, even_nib}, 8'h01);
			if (idx == 20) check(first_frame, p < FRAME_BYTES);
			if (idx == IMAGE_BYTES || idx == IMAGE_BYTES + 1)
				check({odd_nib, even_nib}, {SYNC_ODD, SYNC_EVEN});
			else if (idx == IMAGE_BYTES + 2)
				check({odd_nib, even_nib}, {temp_word[11:8], temp_word[15:12]});
			else if (idx == IMAGE_BYTES + 3)
				check({underrun, odd_nib, even_nib}, {1'b0, temp_word[3:0], temp_word[7:4]});
			else if (img && p > FRAME_BYTES && idx > 0)
				check({odd_nib, even_nib}, {last + 4'h1, last + 4'h2});
			last = odd_nib;
			if (img && p == FRAME_BYTES + 600) begin
				i_host_pin_model.set_pins(1'b0, 1'b1);
				check({data_oe, data_bus}, {1'b0, 8'hzz});
			end
			if (img && p == FRAME_BYTES + 610) begin
				i_host_pin_model.set_pins(1'b0, 1'b0);
				check({data_oe, data_bus}, {1'b1, odd_nib, even_nib});
			end
		end
	endtask : t_frames
	// Restart mid-frame: sync lands at the same offset again
	task automatic t_restart();
		repeat (300) i_host_pin_model.pulse();
		i_host_pin_model.set_pins(1'b1, 1'b0);
		i_host_pin_model.set_pins(1'b0, 1'b0);
		repeat (4) i_host_pin_model.pulse();
		t_frames(1, 1'b0);
	endtask : t_restart
	// Source stalls: buffer drains, zeros go out, underrun sticks
	task automatic t_starve();
		feed_on = 1'b0;
		repeat (4) i_host_pin_model.pulse();
		check({underrun, odd_nib, even_nib}, 12'h100);
	endtask : t_starve
	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial begin
		repeat (5) @(negedge mclk_i);
		resetn_i = 1'b1;
		feed_on = 1'b1;
		t_hold();
		t_frames(2, 1'b1);
		t_restart();
		t_starve();
		report_and_stop();
	end
	// Watchdog for a hung run
	initial begin
		repeat (60000) @(posedge mclk_i);
		bad_count++;
		report_and_stop();
	end
endmodule : testbench
